// ### rbpr_pkg.sv
`default_nettype none

package rbpr_pkg;

    // ------------------------------------------------------------------
    // Sizes and timing
    // ------------------------------------------------------------------
    localparam int unsigned NUM_PORTS   = 7;
    localparam int unsigned MIN_TX_BITS = 96;
    localparam int unsigned CLK_NS      = 4;
    localparam int unsigned BIT_NS      = 100;
    localparam int unsigned BIT_CYC     = (BIT_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned HALF_CYC    = BIT_CYC / 2;
    localparam int unsigned CYC_W       = 5;
    localparam int unsigned CNT_W       = 8;
    localparam int unsigned CNT_MAX     = (1 << CNT_W) - 1;

    // ------------------------------------------------------------------
    // Synchroniser layout: fixed lines in the low bits
    // ------------------------------------------------------------------
    localparam int unsigned SYNC_FIXED = 6;
    localparam int unsigned SI_CHAIN   = 0;
    localparam int unsigned SI_ACT     = 1;
    localparam int unsigned SI_COL     = 2;
    localparam int unsigned SI_FE      = 3;
    localparam int unsigned SI_SD      = 4;
    localparam int unsigned SI_SC      = 5;
    localparam logic [5:0]  SYNC_IDLE  = 6'h0f;

    // Last two bits of the start-of-frame delimiter
    localparam logic [1:0]  SFD_TAIL   = 2'h3;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_START = 3'h1,
        ST_PRE   = 3'h2,
        ST_DATA  = 3'h3,
        ST_RXCOL = 3'h4,
        ST_WAIT  = 3'h5
    } rbpr_state_e;

    typedef enum logic [1:0] {
        BUS_IDLE   = 2'h0,
        BUS_REPEAT = 2'h1,
        BUS_RXCOL  = 2'h2
    } rbpr_bus_e;

endpackage

`default_nettype wire

// ### rbpr_core.sv
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// - Arbitration picks one receiving port; others transmit
// - Preamble comes from internal pattern generator
// - Receiving device drives decoded data, clock, enable
// - Load buffer only after delimiter seen
// - Send buffered data after enough preamble
// - Falling chain and activity edges announce repeat
// - Start-up delay precedes preamble; arbitration inside it
// - Bus shows merged repeat and idle states
// - At least 96 bits sent once active
// - Short receive goes to collision, jam extends
// - Recovery wait after buffer emptied
// - Port collision drives line; all switch jam (the holder's receiving port gets no jam)
// - Collision state until 96 bits, activity over
// - Three end-of-activity orderings handled
// - Extend collision by second wait with jam
// - After extension wait, unless port receives
// - Bus data ignored after receive collision
// - Local chain priority port 1 highest
// - Activity line driven by holder, wired-OR
// - Frame enable driven only by holder
module rbpr_core #(
    parameter int unsigned NPORT        = rbpr_pkg::NUM_PORTS,
    parameter int unsigned EB_DEPTH     = 2,
    parameter int unsigned STARTUP_BITS = 8,
    parameter int unsigned PRE_BITS     = 16,
    parameter int unsigned TW1_BITS     = 16,
    parameter int unsigned TW2_BITS     = 8
) (
    input  wire logic               ref_clk,
    input  wire logic               rst,
    input  wire logic               clk_en,
    input  wire logic [NPORT-1:0]   port_rx,
    input  wire logic [NPORT-1:0]   port_col,
    input  wire logic               dec_data,
    input  wire logic               dec_valid,
    input  wire logic               dec_lock,
    input  wire logic               arbitration_chain_in_n,
    output logic                    arbitration_chain_out_n,
    input  wire logic               activity_line_in_n,
    output logic                    activity_line_out_n,
    output logic                    activity_line_oe,
    input  wire logic               receive_collision_line_in_n,
    output logic                    receive_collision_line_out_n,
    output logic                    receive_collision_line_oe,
    input  wire logic               bus_frame_enable_in_n,
    output logic                    bus_frame_enable_out_n,
    output logic                    bus_frame_enable_oe,
    input  wire logic               bus_serial_data_in,
    output logic                    bus_serial_data_out,
    output logic                    bus_serial_data_oe,
    input  wire logic               bus_serial_clock_in,
    output logic                    bus_serial_clock_out,
    output logic                    bus_serial_clock_oe,
    output logic [NPORT-1:0]        rx_mux_sel,
    output logic [NPORT-1:0]        tx_port_en,
    output logic                    tx_bit,
    output logic                    tx_valid,
    input  wire logic               tx_ready,
    output logic                    eb_in_ready,
    output rbpr_pkg::rbpr_bus_e     bus_state
);
    import rbpr_pkg::*;

    // ------------------------------------------------------------------
    // Derived constants and parameter checks
    // ------------------------------------------------------------------
    localparam int unsigned SW = 2 * NPORT + SYNC_FIXED;
    localparam int unsigned PW = (EB_DEPTH > 1) ? $clog2(EB_DEPTH) : 1;
    localparam logic [CYC_W-1:0] CYC_LAST = CYC_W'(BIT_CYC - 1);
    localparam logic [CYC_W-1:0] CYC_HALF = CYC_W'(HALF_CYC);
    localparam logic [CNT_W-1:0] MIN_TX   = CNT_W'(MIN_TX_BITS);
    localparam logic [CNT_W-1:0] SU_LAST  = CNT_W'(STARTUP_BITS - 1);
    localparam logic [CNT_W-1:0] PRE_LIM  = CNT_W'(PRE_BITS);
    localparam logic [CNT_W-1:0] TW1_LAST = CNT_W'(TW1_BITS - 1);
    localparam logic [CNT_W-1:0] TW2_LIM  = CNT_W'(TW2_BITS);
    localparam logic [PW:0]      EB_FULL  = (PW + 1)'(EB_DEPTH);

    if (EB_DEPTH < 2 || (EB_DEPTH & (EB_DEPTH - 1)) != 0) begin : g_chk_eb
        $error("EB_DEPTH must be a power of two, at least two");
    end
    if (STARTUP_BITS < 1 || STARTUP_BITS > CNT_MAX || PRE_BITS > CNT_MAX ||
        TW1_BITS < 1 || TW1_BITS > CNT_MAX || TW2_BITS > CNT_MAX ||
        NPORT < 1) begin : g_chk_cnt
        $error("Count or port parameter out of range");
    end

    function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] c,
                                                 input logic [CNT_W-1:0] lim);
        return (c >= lim) ? lim : c + 1'b1;
    endfunction

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [SW-1:0] sync_raw;
    logic [SW-1:0] sync_a_q;
    logic [SW-1:0] sync_b_q;

    assign sync_raw = {port_col, port_rx, bus_serial_clock_in, bus_serial_data_in,
                       bus_frame_enable_in_n, receive_collision_line_in_n,
                       activity_line_in_n, arbitration_chain_in_n};

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sync_a_q <= SW'(SYNC_IDLE);
            sync_b_q <= SW'(SYNC_IDLE);
        end else if (clk_en) begin
            sync_a_q <= sync_raw;
            sync_b_q <= sync_a_q;
        end
    end

    logic             chain_s, act_n_s, receive_collision_line_s, fen_s, sd_s, sc_s;
    logic [NPORT-1:0] rx_s, col_s;
    assign chain_s = sync_b_q[SI_CHAIN];
    assign act_n_s = sync_b_q[SI_ACT];
    assign receive_collision_line_s  = sync_b_q[SI_COL];
    assign fen_s   = sync_b_q[SI_FE];
    assign sd_s    = sync_b_q[SI_SD];
    assign sc_s    = sync_b_q[SI_SC];
    assign rx_s    = sync_b_q[SYNC_FIXED +: NPORT];
    assign col_s   = sync_b_q[SYNC_FIXED + NPORT +: NPORT];

    // ------------------------------------------------------------------
    // Bit timer; a receiver stall holds it at the last cycle
    // ------------------------------------------------------------------
    logic [CYC_W-1:0] cyc_q;
    logic             fire;
    assign fire = (cyc_q == CYC_LAST) && tx_ready;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cyc_q <= '0;
        end else if (clk_en) begin
            if (cyc_q != CYC_LAST) cyc_q <= cyc_q + 1'b1;
            else if (tx_ready) cyc_q <= '0;
        end
    end

    // ------------------------------------------------------------------
    // Shared decode
    // ------------------------------------------------------------------
    rbpr_state_e      state_q;
    logic [CNT_W-1:0] su_cnt_q, pre_cnt_q, tx_cnt_q, tw1_cnt_q, tw2_cnt_q;
    logic [PW:0]      cnt_q;
    logic             col_seen_q, receive_collision_line_d_q, hold_q;
    logic [NPORT-1:0] port_n_q;
    logic             in_arb, col_act, col_fall, rx_end, eb_valid, data_done, short;
    logic             data_bit, rep_tx, repeating;

    assign in_arb    = (state_q == ST_IDLE) || (state_q == ST_START);
    assign repeating = (state_q == ST_PRE) || (state_q == ST_DATA) || (state_q == ST_RXCOL);
    assign col_act   = !receive_collision_line_s;
    assign col_fall  = receive_collision_line_s && !receive_collision_line_d_q;
    assign rx_end    = act_n_s;
    assign eb_valid  = (cnt_q != '0);
    assign data_done = !eb_valid && rx_end;
    assign short     = (tx_cnt_q < MIN_TX);
    assign data_bit  = (state_q == ST_DATA) && eb_valid && !col_act;
    assign rep_tx    = repeating && (state_q != ST_DATA || eb_valid || col_act);

    // ------------------------------------------------------------------
    // Main repeat sequence
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_q <= ST_IDLE;
        end else if (clk_en) begin
            case (state_q)
                ST_IDLE: if (!act_n_s) state_q <= ST_START;
                ST_START: begin
                    if (act_n_s) state_q <= ST_IDLE;
                    else if (fire && su_cnt_q == SU_LAST) state_q <= ST_PRE;
                end
                ST_PRE: begin
                    if (col_act) state_q <= ST_RXCOL;
                    else if (pre_cnt_q >= PRE_LIM && eb_valid) state_q <= ST_DATA;
                    else if (pre_cnt_q >= PRE_LIM && data_done)
                        state_q <= short ? ST_RXCOL : ST_WAIT;
                end
                ST_DATA: begin
                    if (col_act) state_q <= ST_RXCOL;
                    else if (data_done) state_q <= short ? ST_RXCOL : ST_WAIT;
                end
                // Any order of receive end and collision end meets here
                ST_RXCOL: begin
                    if (!short && rx_end && !col_act && !col_fall && tw2_cnt_q == '0)
                        state_q <= ST_WAIT;
                end
                ST_WAIT: if (fire && tw1_cnt_q == TW1_LAST) state_q <= ST_IDLE;
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Bit-time counters
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            su_cnt_q  <= '0;
            pre_cnt_q <= '0;
            tx_cnt_q  <= '0;
            tw1_cnt_q <= '0;
            tw2_cnt_q <= '0;
            receive_collision_line_d_q  <= 1'b1;
        end else if (clk_en) begin
            receive_collision_line_d_q <= receive_collision_line_s;
            if (state_q != ST_START) su_cnt_q <= '0;
            else if (fire) su_cnt_q <= su_cnt_q + 1'b1;
            if (state_q != ST_WAIT) tw1_cnt_q <= '0;
            else if (fire) tw1_cnt_q <= tw1_cnt_q + 1'b1;
            if (in_arb) begin
                pre_cnt_q <= '0;
                tx_cnt_q  <= '0;
            end else if (fire && rep_tx) begin
                tx_cnt_q <= sat_inc(tx_cnt_q, MIN_TX);
                if (state_q == ST_PRE) pre_cnt_q <= sat_inc(pre_cnt_q, PRE_LIM);
            end
            if (state_q == ST_RXCOL && col_fall) tw2_cnt_q <= TW2_LIM;
            else if (fire && tw2_cnt_q != '0) tw2_cnt_q <= tw2_cnt_q - 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Port arbitration and wired-OR lines
    // ------------------------------------------------------------------
    logic [NPORT-1:0] local_act, win_oh;
    logic             local_any, cand;
    logic             chain_out_q, act_oe_q, col_oe_q;

    assign local_act = rx_s | col_s;
    assign local_any = |local_act;
    assign win_oh    = local_act & (~local_act + 1'b1);
    assign cand      = chain_s && local_any;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            hold_q      <= 1'b0;
            port_n_q    <= '0;
            chain_out_q <= 1'b1;
            act_oe_q    <= 1'b0;
            col_oe_q    <= 1'b0;
        end else if (clk_en) begin
            // Frozen once preamble starts so the holder cannot change mid-frame
            if (in_arb) begin
                hold_q   <= cand;
                port_n_q <= cand ? win_oh : '0;
            end
            chain_out_q <= chain_s && !(in_arb ? local_any : hold_q);
            act_oe_q <= in_arb ? cand : (hold_q && (local_act & port_n_q) != '0);
            col_oe_q <= hold_q && !in_arb && (col_s & port_n_q) != '0;
        end
    end

    assign arbitration_chain_out_n      = chain_out_q;
    assign activity_line_out_n          = 1'b0;
    assign activity_line_oe             = act_oe_q;
    assign receive_collision_line_out_n = 1'b0;
    assign receive_collision_line_oe    = col_oe_q;
    assign rx_mux_sel                   = port_n_q;

    // ------------------------------------------------------------------
    // Bus drive by the holder
    // ------------------------------------------------------------------
    logic             drv_q, sd_q, sc_q;
    logic [CYC_W-1:0] sc_cnt_q;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            drv_q    <= 1'b0;
            sd_q     <= 1'b0;
            sc_q     <= 1'b0;
            sc_cnt_q <= '0;
        end else if (clk_en) begin
            drv_q <= hold_q && dec_lock && !col_seen_q &&
                     (state_q == ST_PRE || state_q == ST_DATA);
            // Clock rises a cycle after data so receivers see settled data
            if (dec_valid) begin
                sd_q     <= dec_data;
                sc_cnt_q <= CYC_HALF;
            end else if (sc_cnt_q != '0) begin
                sc_cnt_q <= sc_cnt_q - 1'b1;
            end
            sc_q <= (sc_cnt_q != '0);
        end
    end

    assign bus_frame_enable_out_n = 1'b0;
    assign bus_frame_enable_oe    = drv_q;
    assign bus_serial_data_out    = sd_q;
    assign bus_serial_data_oe     = drv_q;
    assign bus_serial_clock_out   = sc_q;
    assign bus_serial_clock_oe    = drv_q;

    // ------------------------------------------------------------------
    // Bus receive, delimiter search and elasticity buffer
    // ------------------------------------------------------------------
    logic          sc_d_q, sh_q, sfd_q, bit_stb, rx_open, push, pop, flush;
    logic          mem_q [EB_DEPTH];
    logic [PW-1:0] wp_q, rp_q;

    assign bit_stb     = sc_s && !sc_d_q && !fen_s;
    assign rx_open     = !col_seen_q && !col_act && (state_q == ST_START ||
                         state_q == ST_PRE || state_q == ST_DATA);
    assign eb_in_ready = (cnt_q != EB_FULL);
    assign push        = bit_stb && sfd_q && rx_open && eb_in_ready;
    assign pop         = fire && data_bit;
    assign flush       = (state_q == ST_IDLE) || (state_q == ST_WAIT);

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sc_d_q     <= 1'b0;
            sh_q       <= 1'b0;
            sfd_q      <= 1'b0;
            col_seen_q <= 1'b0;
        end else if (clk_en) begin
            sc_d_q <= sc_s;
            if (state_q == ST_IDLE) begin
                sh_q       <= 1'b0;
                sfd_q      <= 1'b0;
                col_seen_q <= 1'b0;
            end else begin
                if (col_act) col_seen_q <= 1'b1;
                if (bit_stb && rx_open && !sfd_q) begin
                    sh_q <= sd_s;
                    if ({sh_q, sd_s} == SFD_TAIL) sfd_q <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (clk_en && push) mem_q[wp_q] <= sd_s;
    end

    always_ff @(posedge ref_clk) begin
        if (rst || (clk_en && flush)) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else if (clk_en) begin
            if (push) wp_q <= wp_q + 1'b1;
            if (pop) rp_q <= rp_q + 1'b1;
            cnt_q <= cnt_q + (PW + 1)'(push) - (PW + 1)'(pop);
        end
    end

    // ------------------------------------------------------------------
    // Transmit side
    // ------------------------------------------------------------------
    logic             tx_bit_q, tx_valid_q, pat_q;
    logic [NPORT-1:0] tx_en_q;
    rbpr_bus_e        bus_state_q;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            tx_bit_q    <= 1'b0;
            tx_valid_q  <= 1'b0;
            pat_q       <= 1'b1;
            tx_en_q     <= '0;
            bus_state_q <= BUS_IDLE;
        end else if (clk_en) begin
            tx_valid_q <= fire && rep_tx;
            if (in_arb) begin
                pat_q <= 1'b1;
            end else if (fire && rep_tx) begin
                if (data_bit) begin
                    tx_bit_q <= mem_q[rp_q];
                end else begin
                    tx_bit_q <= pat_q;
                    pat_q    <= !pat_q;
                end
            end
            tx_en_q <= repeating ? (hold_q ? ~port_n_q : '1) : '0;
            case (state_q)
                ST_PRE, ST_DATA: bus_state_q <= BUS_REPEAT;
                ST_RXCOL:        bus_state_q <= BUS_RXCOL;
                default:         bus_state_q <= BUS_IDLE;
            endcase
        end
    end

    assign tx_bit     = tx_bit_q;
    assign tx_valid   = tx_valid_q;
    assign tx_port_en = tx_en_q;
    assign bus_state  = bus_state_q;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst || !clk_en);

    a_port_excl: assert property (hold_q && state_q == ST_DATA |-> (tx_en_q & port_n_q) == '0)
        else $error("Receiving port is transmitting");
    a_one_port: assert property (hold_q |-> $onehot(port_n_q))
        else $error("Holder without exactly one port");
    a_pre_pattern: assert property (state_q == ST_PRE && fire |=> tx_valid_q && tx_bit_q == $past(pat_q))
        else $error("Preamble bit not from generator");
    a_bus_owner: assert property (bus_frame_enable_oe |-> $past(hold_q) && $past(dec_lock))
        else $error("Frame enable driven by non-holder");
    a_sfd_gate: assert property ($rose(sfd_q) |-> $past(bit_stb) && $past(sh_q) && $past(sd_s))
        else $error("Buffer loaded before delimiter");
    a_pre_first: assert property (state_q == ST_DATA && $past(state_q) == ST_PRE |-> $past(pre_cnt_q) >= PRE_LIM)
        else $error("Data before enough preamble");
    a_chain_hold: assert property (in_arb && cand |=> !arbitration_chain_out_n)
        else $error("Chain out not asserted");
    a_startup: assert property (state_q == ST_PRE && $past(state_q) == ST_START |-> $past(su_cnt_q) == SU_LAST)
        else $error("Start-up delay cut short");
    a_bus_map: assert property ($past(state_q) == ST_DATA |-> bus_state == BUS_REPEAT)
        else $error("Send data not shown as repeat");
    a_min_bits: assert property (state_q == ST_WAIT |-> tx_cnt_q == MIN_TX)
        else $error("Wait entered before 96 bits");
    a_frag_ext: assert property (state_q == ST_DATA && !col_act && data_done && short |=> state_q == ST_RXCOL)
        else $error("Short frame not extended");
    a_col_jam: assert property ((state_q == ST_PRE || state_q == ST_DATA) && col_act |=> state_q == ST_RXCOL)
        else $error("Collision line ignored");
    a_tw2_hold: assert property (state_q == ST_RXCOL && tw2_cnt_q != '0 |=> state_q == ST_RXCOL)
        else $error("Left collision during extension");
    a_wait_tw1: assert property (state_q == ST_IDLE && $past(state_q) == ST_WAIT |-> $past(tw1_cnt_q) == TW1_LAST)
        else $error("Recovery wait cut short");

    c_data_done: cover property (state_q == ST_DATA ##1 state_q == ST_WAIT);
    c_rx_col: cover property (state_q == ST_RXCOL && tw2_cnt_q != '0);
    c_frag: cover property (state_q == ST_DATA && !col_act ##1 state_q == ST_RXCOL);
    c_eb_full: cover property (!eb_in_ready && !tx_ready);

endmodule // rbpr_core

`default_nettype wire

// ### rbpr_peer.sv
`timescale 1ns/100ps
`default_nettype none
// Far-side repeater controller holding the receiving port
module rbpr_peer (
    input  wire logic hold,
    input  wire logic col,
    output logic      act_n,
    output logic      col_n,
    output logic      fe_n,
    output logic      sd,
    output logic      sc
);
    int n = 0;
    assign act_n = ~hold;
    assign col_n = ~col;
    assign fe_n  = ~hold;
    // Clock stands still between frames; released data keeps toggling
    initial begin
        sc = 1'b0;
        sd = 1'b0;
        forever begin
            #32;
            if (hold && !sc) begin
                sc = 1'b1;
            end else begin
                sc = 1'b0;
                n  = hold ? n + 1 : 0;
                sd = !hold ? ~sd : (n < 14) ? n[0] : (n < 16) ? 1'b1 : n[2];
            end
        end
    end
endmodule // rbpr_peer
`default_nettype wire

// ### tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
    import rbpr_pkg::*;
    logic ref_clk = 0, rst = 1, dec_lock = 0, dec_valid = 0, dec_data = 0, tx_ready = 1, clk_en = 1;
    logic chain_in_n = 1, hold = 0, col = 0, seen_col = 0, seen_full = 0, b;
    logic [6:0] port_rx = 7'h00, port_col = 7'h00, rx_mux_sel, tx_port_en;
    logic chain_out_n, act_oe, act_o, col_oe, col_o, fe_oe, fe_o, sd_o, sd_oe, sc_o, sc_oe;
    logic tx_bit, tx_valid, eb_in_ready, p_act_n, p_col_n, p_fe_n, p_sd, p_sc;
    rbpr_bus_e bus_state;
    int err_count = 0, n_checks = 0, cyc = 0, nbits = 0, dv = 0;
    rbpr_core #(.STARTUP_BITS(2), .PRE_BITS(4), .TW1_BITS(2), .TW2_BITS(2)) rbpr_core_i (
        .ref_clk, .rst, .clk_en, .port_rx, .port_col, .dec_data, .dec_valid,
        .dec_lock, .arbitration_chain_in_n(chain_in_n), .arbitration_chain_out_n(chain_out_n),
        .activity_line_in_n(p_act_n & (act_o | ~act_oe)), .activity_line_out_n(act_o),
        .activity_line_oe(act_oe), .receive_collision_line_out_n(col_o),
        .receive_collision_line_in_n(p_col_n & (col_o | ~col_oe)), .receive_collision_line_oe(col_oe),
        .bus_frame_enable_in_n(fe_oe ? fe_o : p_fe_n), .bus_frame_enable_out_n(fe_o),
        .bus_frame_enable_oe(fe_oe), .bus_serial_data_in(sd_oe ? sd_o : p_sd),
        .bus_serial_data_out(sd_o), .bus_serial_data_oe(sd_oe),
        .bus_serial_clock_in(sc_oe ? sc_o : p_sc), .bus_serial_clock_out(sc_o),
        .bus_serial_clock_oe(sc_oe), .rx_mux_sel, .tx_port_en, .tx_bit, .tx_valid, .tx_ready,
        .eb_in_ready, .bus_state);
    rbpr_peer rbpr_peer_i (.hold, .col, .act_n(p_act_n), .col_n(p_col_n), .fe_n(p_fe_n),
        .sd(p_sd), .sc(p_sc));
    initial forever #2 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        nbits <= nbits + int'(tx_valid === 1'b1);
        if (bus_state === BUS_RXCOL) seen_col <= 1'b1;
        if (eb_in_ready === 1'b0) seen_full <= 1'b1;
        dv <= (dv == 24) ? 0 : dv + 1;
        dec_valid <= (dv == 24);
        if (dv == 24) dec_data <= ~dec_data;
        if (cyc == 60000) begin
            err_count++;
            finish_test();
        end
    end
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wait_st(input rbpr_bus_e s, input int lim);
        int k;
        k = 0;
        while (bus_state !== s && k < lim) begin
            @(posedge ref_clk);
            #1;
            k++;
        end
        chk("bus_state", 8'(s), 8'(bus_state));
    endtask
    task automatic t_local;
        int b0, s0;
        b0 = nbits;
        @(posedge ref_clk);
        port_rx  <= 7'h06;
        dec_lock <= 1'b1;
        wait_st(BUS_REPEAT, 800);
        repeat (4) @(posedge ref_clk);
        #1;
        chk("rx_mux_sel", 8'h02, 8'(rx_mux_sel));
        chk("tx_port_en", 8'h7d, 8'(tx_port_en));
        chk("chain_out_n", 8'h00, 8'(chain_out_n));
        chk("act_oe", 8'h01, 8'(act_oe));
        chk("frame_oe", 8'h01, 8'(fe_oe));
        @(posedge tx_valid);
        #1;
        b = tx_bit;
        @(posedge tx_valid);
        #1;
        chk("preamble", {7'h00, ~b}, 8'(tx_bit));
        @(posedge ref_clk);
        tx_ready <= 1'b0;
        repeat (3) @(posedge ref_clk);
        s0 = nbits;
        repeat (60) @(posedge ref_clk);
        chk("stalled_bits", 8'h00, 8'(nbits - s0));
        tx_ready <= 1'b1;
        port_rx  <= 7'h00;
        dec_lock <= 1'b0;
        wait_st(BUS_IDLE, 6000);
        chk("fragment_col", 8'h01, 8'(seen_col));
        chk("min_bits", 8'h01, 8'(nbits - b0 >= 96));
        $display("test local_short done");
    endtask
    task automatic t_peer(input logic jam);
        int b0;
        b0 = nbits;
        seen_col = 1'b0;
        @(posedge ref_clk);
        chain_in_n <= 1'b0;
        hold       <= 1'b1;
        wait_st(BUS_REPEAT, 800);
        #1;
        chk("rx_mux_sel", 8'h00, 8'(rx_mux_sel));
        chk("tx_port_en", 8'h7f, 8'(tx_port_en));
        chk("act_oe", 8'h00, 8'(act_oe));
        repeat (jam ? 200 : 3000) @(posedge ref_clk);
        col <= jam;
        if (jam) wait_st(BUS_RXCOL, 8);
        @(posedge ref_clk);
        hold       <= 1'b0;
        col        <= 1'b0;
        chain_in_n <= 1'b1;
        repeat (100) @(posedge ref_clk);
        #1;
        if (jam) chk("col_hold", 8'(BUS_RXCOL), 8'(bus_state));
        wait_st(BUS_IDLE, 6000);
        chk("min_bits", 8'h01, 8'(nbits - b0 >= 96));
        if (!jam) chk("buffer_full", 8'h01, 8'(seen_full));
        $display("test peer_frame jam=%0d done", jam);
    endtask
    task automatic t_lcol;
        @(posedge ref_clk);
        port_rx  <= 7'h01;
        dec_lock <= 1'b1;
        wait_st(BUS_REPEAT, 800);
        chk("rx_mux_sel", 8'h01, 8'(rx_mux_sel));
        @(posedge ref_clk);
        port_col <= 7'h01;
        wait_st(BUS_RXCOL, 12);
        chk("col_oe", 8'h01, 8'(col_oe));
        chk("frame_oe", 8'h00, 8'(fe_oe));
        @(posedge ref_clk);
        port_col <= 7'h00;
        port_rx  <= 7'h00;
        dec_lock <= 1'b0;
        wait_st(BUS_IDLE, 6000);
        $display("test local_collision done");
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        #1;
        chk("idle_state", 8'(BUS_IDLE), 8'(bus_state));
        chk("idle_tx_en", 8'h00, 8'(tx_port_en));
        @(posedge ref_clk);
        clk_en  <= 1'b0;
        port_rx <= 7'h01;
        repeat (20) @(posedge ref_clk);
        chk("frozen_act_oe", 8'h00, 8'(act_oe));
        clk_en  <= 1'b1;
        port_rx <= 7'h00;
        $display("test freeze done");
        t_local();
        t_lcol();
        t_peer(1'b0);
        t_peer(1'b1);
        finish_test();
    end
endmodule // tb
`default_nettype wire
